// ---- rtl/barometer_pkg.sv ----
// register map, field positions, reset values and rate timing
// assumes a 200 MHz ref_clk
package barometer_pkg;
  localparam logic [6:0] ADDR_REF_LOW = 7'h08;
  localparam logic [6:0] ADDR_REF_MID = 7'h09;
  localparam logic [6:0] ADDR_REF_HIGH = 7'h0A;
  localparam logic [6:0] ADDR_IDENTITY = 7'h0F;
  localparam logic [6:0] ADDR_AVG_CFG = 7'h10;
  localparam logic [6:0] ADDR_MAIN_CTRL = 7'h20;
  localparam logic [6:0] ADDR_SEC_CTRL = 7'h21;
  localparam logic [6:0] ADDR_PIN_CTRL = 7'h22;
  localparam logic [6:0] ADDR_PIN_SRC = 7'h23;
  localparam logic [6:0] ADDR_EVT_CFG = 7'h24;
  localparam logic [6:0] ADDR_EVT_SRC = 7'h25;
  localparam logic [6:0] ADDR_STATUS = 7'h27;
  localparam logic [6:0] ADDR_POUT_LOW = 7'h28;
  localparam logic [6:0] ADDR_POUT_MID = 7'h29;
  localparam logic [6:0] ADDR_POUT_HIGH = 7'h2A;
  localparam logic [6:0] ADDR_TOUT_LOW = 7'h2B;
  localparam logic [6:0] ADDR_TOUT_HIGH = 7'h2C;
  localparam logic [6:0] ADDR_QUEUE_CTRL = 7'h2E;
  localparam logic [6:0] ADDR_QUEUE_STAT = 7'h2F;
  localparam logic [6:0] ADDR_THS_LOW = 7'h30;
  localparam logic [6:0] ADDR_THS_HIGH = 7'h31;
  localparam logic [6:0] ADDR_AZP_LOW = 7'h39;
  localparam logic [6:0] ADDR_AZP_HIGH = 7'h3A;
  // identity value is arbitrary
  localparam logic [7:0] IDENTITY_VALUE = 8'h5A;
  localparam logic [3:0] AVG_CFG_RESET = 4'h5;
  // main control fields
  localparam int POWER_ON_BIT = 7;
  localparam int RATE_MSB = 6;
  localparam int RATE_LSB = 4;
  localparam int DIFFERENTIAL_ENABLE_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int AZ_CLEAR_BIT = 1;
  localparam int WIRE_SEL_BIT = 0;
  // secondary control fields
  localparam int BOOT_BIT = 7;
  localparam int AUTOZERO_BIT = 1;
  localparam int ONE_SHOT_BIT = 0;
  // event config / source fields
  localparam int HIGH_EN_BIT = 0;
  localparam int LOW_EN_BIT = 1;
  localparam int LATCH_BIT = 2;
  // status fields
  localparam int T_AVAIL_BIT = 0;
  localparam int P_AVAIL_BIT = 1;
  localparam int T_OVER_BIT = 4;
  localparam int P_OVER_BIT = 5;
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [2:0] RATE_1HZ = 3'h1;
  localparam logic [2:0] RATE_7HZ = 3'h2;
  localparam logic [2:0] RATE_12HZ5 = 3'h3;
  localparam logic [2:0] RATE_25HZ = 3'h4;
  // rates in centihertz, periods derived from the clock
  localparam longint CLK_HZ = 200_000_000;
  localparam longint RATE_1HZ_CHZ = 100;
  localparam longint RATE_7HZ_CHZ = 700;
  localparam longint RATE_12HZ5_CHZ = 1250;
  localparam longint RATE_25HZ_CHZ = 2500;
  localparam int PERIOD_1HZ = int'(CLK_HZ * 100 / RATE_1HZ_CHZ);
  localparam int PERIOD_7HZ = int'(CLK_HZ * 100 / RATE_7HZ_CHZ);
  localparam int PERIOD_12HZ5 = int'(CLK_HZ * 100 / RATE_12HZ5_CHZ);
  localparam int PERIOD_25HZ = int'(CLK_HZ * 100 / RATE_25HZ_CHZ);
endpackage

// ---- rtl/barometer_control_registers.sv ----
// register bank and main control of the barometer core
// assumes a serial engine that turns frames into byte strobes and a
// conversion path that answers each start with one sample
`timescale 1ns/1ps
module barometer_control_registers
  import barometer_pkg::*;
#(
  parameter int Period1Hz = PERIOD_1HZ,
  parameter int Period7Hz = PERIOD_7HZ,
  parameter int Period12Hz5 = PERIOD_12HZ5,
  parameter int Period25Hz = PERIOD_25HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port from the serial engine
  input wire logic [6:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // conversion path
  output logic measureStart,
  input wire logic sampleValid,
  input wire logic [23:0] pressureRaw,
  input wire logic [15:0] temperatureRaw,
  output logic [6:0] temperatureAverages,
  output logic [9:0] pressureAverages,
  // misc controls and events
  output logic powerOn,
  output logic spiThreeWire,
  output logic calibReload,
  output logic thresholdEvent
);
  typedef enum logic {IDLE, CONVERT} meas_e;

  typedef struct packed {
    logic [23:0] refP;
    logic [3:0] avgCfg;
    logic [7:0] mainCtrl;
    logic [7:0] secCtrl;
    logic [7:0] pinCtrl;
    logic [7:0] pinSrc;
    logic [7:0] evtCfg;
    logic [2:0] evtSrc;
    logic [7:0] status;
    logic [15:0] thsP;
    logic [15:0] azp;
    logic [7:0] queueCtrl;
    logic [23:0] pressOut;
    logic [15:0] tempOut;
    logic [7:0] rdata;
    logic [31:0] rateCnt;
    meas_e meas;
    logic outLocked;
    logic hiRead;
    logic loRead;
    logic pwrUpPending;
    logic bootPulse;
    logic start;
  } state_s;

  state_s cur_ff, nxt_cur;

  if (Period1Hz < 2 || Period7Hz < 2 || Period12Hz5 < 2 || Period25Hz < 2)
  begin : chk_period
    $error("rate periods must be at least two cycles");
  end

  logic [2:0] rate;
  logic rateLegal;
  logic [31:0] period;
  logic rateTick;
  logic [23:0] diff;
  logic azOn;
  logic wr;
  logic rd;

  assign rate = cur_ff.mainCtrl[RATE_MSB:RATE_LSB];
  assign azOn = cur_ff.secCtrl[AUTOZERO_BIT];
  assign diff = pressureRaw - cur_ff.refP;
  assign wr = regWrite;
  assign rd = regRead;

  always_comb begin
    rateLegal = 1'b1;
    unique case (rate)
      RATE_1HZ: period = 32'(Period1Hz);
      RATE_7HZ: period = 32'(Period7Hz);
      RATE_12HZ5: period = 32'(Period12Hz5);
      RATE_25HZ: period = 32'(Period25Hz);
      default: begin
        period = 32'h0000_0000;
        rateLegal = 1'b0;
      end
    endcase
  end

  assign rateTick = rateLegal && cur_ff.rateCnt == period - 32'h0000_0001;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.start = 1'b0;
    nxt_cur.bootPulse = 1'b0;
    // calibration reload once after power-up
    if (cur_ff.pwrUpPending) begin
      nxt_cur.pwrUpPending = 1'b0;
      nxt_cur.bootPulse = 1'b1;
    end
    if (cur_ff.secCtrl[BOOT_BIT]) begin
      nxt_cur.secCtrl[BOOT_BIT] = 1'b0;
      nxt_cur.bootPulse = 1'b1;
    end

    // rate timer runs only when powered and in continuous mode
    // a control write restarts it, so a shorter period is never overshot
    if (cur_ff.mainCtrl[POWER_ON_BIT] && rateLegal && !rateTick
        && !(wr && regAddr == ADDR_MAIN_CTRL)) begin
      nxt_cur.rateCnt = cur_ff.rateCnt + 32'h0000_0001;
    end else begin
      nxt_cur.rateCnt = 32'h0000_0000;
    end

    // conversion sequencing
    unique case (cur_ff.meas)
      IDLE: begin
        if (cur_ff.mainCtrl[POWER_ON_BIT]) begin
          if ((rate == RATE_ONE_SHOT && cur_ff.secCtrl[ONE_SHOT_BIT])
              || rateTick) begin
            nxt_cur.start = 1'b1;
            nxt_cur.meas = CONVERT;
          end
        end
      end
      CONVERT: begin
        if (!cur_ff.mainCtrl[POWER_ON_BIT]) begin
          nxt_cur.meas = IDLE;
        end else if (sampleValid) begin
          nxt_cur.meas = IDLE;
          nxt_cur.secCtrl[ONE_SHOT_BIT] = 1'b0;
          if (cur_ff.outLocked) begin
            // held sample is kept, the new one is lost
            nxt_cur.status[P_OVER_BIT] = 1'b1;
            nxt_cur.status[T_OVER_BIT] = 1'b1;
          end else begin
            nxt_cur.pressOut = azOn ? diff : pressureRaw;
            nxt_cur.tempOut = temperatureRaw;
            nxt_cur.status[P_OVER_BIT] = cur_ff.status[P_AVAIL_BIT];
            nxt_cur.status[T_OVER_BIT] = cur_ff.status[T_AVAIL_BIT];
            nxt_cur.status[P_AVAIL_BIT] = 1'b1;
            nxt_cur.status[T_AVAIL_BIT] = 1'b1;
            if (cur_ff.mainCtrl[HOLD_BIT]) begin
              nxt_cur.outLocked = 1'b1;
              nxt_cur.hiRead = 1'b0;
              nxt_cur.loRead = 1'b0;
            end
          end
          if (cur_ff.mainCtrl[DIFFERENTIAL_ENABLE_BIT]) begin
            if (cur_ff.evtCfg[HIGH_EN_BIT]
                && $signed(diff) > $signed({8'h00, cur_ff.thsP}))
              nxt_cur.evtSrc[HIGH_EN_BIT] = 1'b1;
            if (cur_ff.evtCfg[LOW_EN_BIT]
                && $signed(diff) < -$signed({8'h00, cur_ff.thsP}))
              nxt_cur.evtSrc[LOW_EN_BIT] = 1'b1;
          end
        end
      end
    endcase

    // host reads; clear-on-read loses to a same-cycle set
    if (rd) begin
      unique case (regAddr)
        ADDR_REF_LOW: nxt_cur.rdata = cur_ff.refP[7:0];
        ADDR_REF_MID: nxt_cur.rdata = cur_ff.refP[15:8];
        ADDR_REF_HIGH: nxt_cur.rdata = cur_ff.refP[23:16];
        ADDR_IDENTITY: nxt_cur.rdata = IDENTITY_VALUE;
        ADDR_AVG_CFG: nxt_cur.rdata = {4'h0, cur_ff.avgCfg};
        ADDR_MAIN_CTRL: nxt_cur.rdata = cur_ff.mainCtrl;
        ADDR_SEC_CTRL: nxt_cur.rdata = cur_ff.secCtrl;
        ADDR_PIN_CTRL: nxt_cur.rdata = cur_ff.pinCtrl;
        ADDR_PIN_SRC: nxt_cur.rdata = cur_ff.pinSrc;
        ADDR_EVT_CFG: nxt_cur.rdata = cur_ff.evtCfg;
        ADDR_EVT_SRC: begin
          nxt_cur.rdata = {5'h00, |cur_ff.evtSrc[1:0], cur_ff.evtSrc[1:0]};
          if (!(nxt_cur.evtSrc[1:0] != cur_ff.evtSrc[1:0]))
            nxt_cur.evtSrc = 3'h0;
        end
        ADDR_STATUS: nxt_cur.rdata = cur_ff.status;
        ADDR_POUT_LOW: begin
          nxt_cur.rdata = cur_ff.pressOut[7:0];
          nxt_cur.loRead = 1'b1;
        end
        ADDR_POUT_MID: nxt_cur.rdata = cur_ff.pressOut[15:8];
        ADDR_POUT_HIGH: begin
          nxt_cur.rdata = cur_ff.pressOut[23:16];
          nxt_cur.hiRead = 1'b1;
          if (!sampleValid || cur_ff.meas != CONVERT) begin
            nxt_cur.status[P_AVAIL_BIT] = 1'b0;
            nxt_cur.status[P_OVER_BIT] = 1'b0;
          end
        end
        ADDR_TOUT_LOW: nxt_cur.rdata = cur_ff.tempOut[7:0];
        ADDR_TOUT_HIGH: begin
          nxt_cur.rdata = cur_ff.tempOut[15:8];
          if (!sampleValid || cur_ff.meas != CONVERT) begin
            nxt_cur.status[T_AVAIL_BIT] = 1'b0;
            nxt_cur.status[T_OVER_BIT] = 1'b0;
          end
        end
        ADDR_QUEUE_CTRL: nxt_cur.rdata = cur_ff.queueCtrl;
        ADDR_THS_LOW: nxt_cur.rdata = cur_ff.thsP[7:0];
        ADDR_THS_HIGH: nxt_cur.rdata = cur_ff.thsP[15:8];
        ADDR_AZP_LOW: nxt_cur.rdata = cur_ff.azp[7:0];
        ADDR_AZP_HIGH: nxt_cur.rdata = cur_ff.azp[15:8];
        // queue status has no queue behind it; reserved reads zero
        default: nxt_cur.rdata = 8'h00;
      endcase
    end
    if (nxt_cur.hiRead && nxt_cur.loRead) begin
      nxt_cur.outLocked = 1'b0;
    end
    if (!cur_ff.mainCtrl[HOLD_BIT]) begin
      nxt_cur.outLocked = 1'b0;
    end

    // host writes; read-only and reserved locations fall through
    if (wr) begin
      unique case (regAddr)
        ADDR_REF_LOW: nxt_cur.refP[7:0] = regWdata;
        ADDR_REF_MID: nxt_cur.refP[15:8] = regWdata;
        ADDR_REF_HIGH: nxt_cur.refP[23:16] = regWdata;
        ADDR_AVG_CFG: nxt_cur.avgCfg = regWdata[3:0];
        ADDR_MAIN_CTRL: begin
          nxt_cur.mainCtrl = regWdata;
          nxt_cur.mainCtrl[AZ_CLEAR_BIT] = 1'b0;
          if (regWdata[AZ_CLEAR_BIT]) begin
            nxt_cur.refP = 24'h00_0000;
            nxt_cur.azp = 16'h0000;
          end
        end
        ADDR_SEC_CTRL: begin
          nxt_cur.secCtrl = regWdata;
          // a trigger whose conversion is starting or under way is not cancelled by a rewrite
          if (cur_ff.secCtrl[ONE_SHOT_BIT] && nxt_cur.meas == CONVERT)
            nxt_cur.secCtrl[ONE_SHOT_BIT] = 1'b1;
          if (regWdata[AUTOZERO_BIT] && !azOn)
            nxt_cur.refP = cur_ff.pressOut;
        end
        ADDR_PIN_CTRL: nxt_cur.pinCtrl = regWdata;
        ADDR_PIN_SRC: nxt_cur.pinSrc = regWdata;
        ADDR_EVT_CFG: nxt_cur.evtCfg = regWdata;
        ADDR_QUEUE_CTRL: nxt_cur.queueCtrl = regWdata;
        ADDR_THS_LOW: nxt_cur.thsP[7:0] = regWdata;
        ADDR_THS_HIGH: nxt_cur.thsP[15:8] = regWdata;
        ADDR_AZP_LOW: nxt_cur.azp[7:0] = regWdata;
        ADDR_AZP_HIGH: nxt_cur.azp[15:8] = regWdata;
        default: ;
      endcase
    end
    // without latching a source bit is set only when the newest sample trips it and it was clear before
    nxt_cur.evtSrc[2] = |nxt_cur.evtSrc[1:0];
    if (!cur_ff.evtCfg[LATCH_BIT] && cur_ff.meas == CONVERT && sampleValid
        && !(rd && regAddr == ADDR_EVT_SRC)) begin
      nxt_cur.evtSrc[1:0] = nxt_cur.evtSrc[1:0] & ~cur_ff.evtSrc[1:0]
                            | (nxt_cur.evtSrc[1:0] ^ cur_ff.evtSrc[1:0]);
      nxt_cur.evtSrc[2] = |nxt_cur.evtSrc[1:0];
    end
    if (!cur_ff.mainCtrl[DIFFERENTIAL_ENABLE_BIT]) begin
      nxt_cur.evtSrc = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.avgCfg <= AVG_CFG_RESET;
      cur_ff.meas <= IDLE;
      cur_ff.pwrUpPending <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_comb begin
    unique case (cur_ff.avgCfg[3:2])
      2'h0: temperatureAverages = 7'h08;
      2'h1: temperatureAverages = 7'h10;
      2'h2: temperatureAverages = 7'h20;
      2'h3: temperatureAverages = 7'h40;
    endcase
    unique case (cur_ff.avgCfg[1:0])
      2'h0: pressureAverages = 10'h008;
      2'h1: pressureAverages = 10'h020;
      2'h2: pressureAverages = 10'h080;
      2'h3: pressureAverages = 10'h200;
    endcase
  end

  assign regRdata = cur_ff.rdata;
  assign measureStart = cur_ff.start;
  assign powerOn = cur_ff.mainCtrl[POWER_ON_BIT];
  assign spiThreeWire = cur_ff.mainCtrl[WIRE_SEL_BIT];
  assign calibReload = cur_ff.bootPulse;
  assign thresholdEvent = cur_ff.evtSrc[2];

  sequence oneShotWrite;
    wr && regAddr == ADDR_SEC_CTRL && regWdata[ONE_SHOT_BIT]
      && powerOn && rate == RATE_ONE_SHOT && cur_ff.meas == IDLE;
  endsequence
  sequence convDone;
    cur_ff.meas == CONVERT && sampleValid && powerOn;
  endsequence

  power_down_a: assert property (
    @(posedge ref_clk) disable iff (reset) !powerOn |=> !measureStart)
    else $error("conversion started while powered down");
  one_shot_a: assert property (
    @(posedge ref_clk) disable iff (reset) oneShotWrite |=> ##1 measureStart)
    else $error("one-shot trigger did not start a conversion");
  shot_clear_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    convDone and !cur_ff.outLocked |=>
      !cur_ff.secCtrl[ONE_SHOT_BIT] && cur_ff.status[P_AVAIL_BIT]
      && cur_ff.tempOut == $past(temperatureRaw))
    else $error("completion did not update outputs");
  hold_out_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    cur_ff.outLocked && !(rd || wr) |=> $stable(cur_ff.pressOut))
    else $error("held output changed");
  az_clear_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr && regAddr == ADDR_MAIN_CTRL && regWdata[AZ_CLEAR_BIT] |=>
      cur_ff.refP == 24'h00_0000 && cur_ff.azp == 16'h0000
      && !cur_ff.mainCtrl[AZ_CLEAR_BIT])
    else $error("autozero clear incomplete");
  diff_gate_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !cur_ff.mainCtrl[DIFFERENTIAL_ENABLE_BIT] |=> !thresholdEvent)
    else $error("threshold event while disabled");
  ro_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr && regAddr == ADDR_IDENTITY ##1 rd && regAddr == ADDR_IDENTITY |=>
      regRdata == IDENTITY_VALUE)
    else $error("identity register altered");
  rate_tick_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    measureStart && rate == RATE_25HZ && $past(rate) == RATE_25HZ |->
      $past(cur_ff.rateCnt) == 32'(Period25Hz) - 32'h0000_0001)
    else $error("25 Hz start at wrong count");
  wire_sel_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr && regAddr == ADDR_MAIN_CTRL |=> spiThreeWire == $past(regWdata[0]))
    else $error("wire select not taken");
endmodule

// ---- verification/conversion_model.sv ----
// behavioural conversion path answering each start with one sample
// assumes the bench sets the sample values and the reply speed
`timescale 1ns/1ps
module conversion_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // start and sample source
  input wire logic measureStart,
  input wire logic slow,
  input wire logic [23:0] pIn,
  input wire logic [15:0] tIn,
  // sample to the block
  output logic sampleValid,
  output logic [23:0] pressureRaw,
  output logic [15:0] temperatureRaw
);
  int wait_ff;
  // idle data toggles so a stale sample can never look valid
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_ff <= 0;
      sampleValid <= 1'b0;
      pressureRaw <= 24'h00_0000;
      temperatureRaw <= 16'h0000;
    end else begin
      sampleValid <= !measureStart && wait_ff == 1;
      if (measureStart) begin
        wait_ff <= slow ? 6 : 1;
      end else if (wait_ff > 0) begin
        wait_ff <= wait_ff - 1;
      end
      if (!measureStart && wait_ff == 1) begin
        pressureRaw <= pIn;
        temperatureRaw <= tIn;
      end else begin
        pressureRaw <= ~pressureRaw;
        temperatureRaw <= ~temperatureRaw;
      end
    end
  end
endmodule

// ---- verification/barometer_control_registers_test.sv ----
// self-checking bench for the barometer register bank
// assumes the conversion model on the sample side
`timescale 1ns/1ps
module barometer_control_registers_test;
  import barometer_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] regAddr = 7'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, e;
  logic measureStart, sampleValid, powerOn, spiThreeWire;
  logic calibReload, thresholdEvent, slow = 1'b0, rdSeen = 1'b0;
  logic [23:0] pressureRaw, pIn = 24'h00_0000, v, w, x, z;
  logic [15:0] temperatureRaw, tIn = 16'h0000;
  logic [6:0] temperatureAverages;
  logic [9:0] pressureAverages;
  logic [7:0] expQ[$];
  logic [6:0] addrQ[$];
  int error_cnt = 0, tests_run = 0, b;
  int startCnt = 0, validCnt = 0, calibCnt = 0;
  int n[5] = '{default: 0};
  logic [6:0] ra [19] = '{ADDR_REF_LOW, ADDR_REF_MID, ADDR_REF_HIGH,
    ADDR_IDENTITY, ADDR_AVG_CFG, ADDR_MAIN_CTRL, ADDR_SEC_CTRL,
    ADDR_PIN_CTRL, ADDR_PIN_SRC, ADDR_EVT_CFG, ADDR_EVT_SRC, ADDR_STATUS,
    ADDR_QUEUE_CTRL, ADDR_QUEUE_STAT, ADDR_THS_LOW, ADDR_THS_HIGH,
    ADDR_AZP_LOW, ADDR_AZP_HIGH, 7'h26};

  // short periods keep the rate runs brief
  barometer_control_registers #(.Period1Hz(20), .Period7Hz(16),
    .Period12Hz5(12), .Period25Hz(8)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .measureStart(measureStart),
    .sampleValid(sampleValid), .pressureRaw(pressureRaw),
    .temperatureRaw(temperatureRaw),
    .temperatureAverages(temperatureAverages),
    .pressureAverages(pressureAverages), .powerOn(powerOn),
    .spiThreeWire(spiThreeWire), .calibReload(calibReload),
    .thresholdEvent(thresholdEvent));
  conversion_model u_conv (.ref_clk(ref_clk), .reset(reset),
    .measureStart(measureStart), .slow(slow), .pIn(pIn), .tIn(tIn),
    .sampleValid(sampleValid), .pressureRaw(pressureRaw),
    .temperatureRaw(temperatureRaw));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rdSeen <= regRead;
    startCnt <= startCnt + int'(measureStart === 1'b1);
    validCnt <= validCnt + int'(sampleValid === 1'b1);
    calibCnt <= calibCnt + int'(calibReload === 1'b1);
  end
  // read data stands from the cycle after the read
  always @(negedge ref_clk) begin
    if (rdSeen === 1'b1 && expQ.size() > 0) begin
      check($sformatf("reg %h", addrQ.pop_front()), {16'h0000, regRdata},
        {16'h0000, expQ.pop_front()});
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] ex);
    addrQ.push_back(a);
    expQ.push_back(ex);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd3(logic [6:0] a, logic [23:0] ex);
    rd(a, ex[7:0]);
    rd(a + 7'h01, ex[15:8]);
    rd(a + 7'h02, ex[23:16]);
  endtask
  task automatic oneShot(logic [23:0] p, logic [7:0] c2);
    int i;
    b = validCnt;
    pIn <= p;
    slow <= 1'($urandom_range(1));
    wr(ADDR_SEC_CTRL, c2 | 8'h01);
    for (i = 0; i < 40 && validCnt <= b; i++) @(posedge ref_clk);
    if (validCnt <= b) begin
      error_cnt++;
      print_verdict();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  initial begin
    void'($urandom(32'hdb4b));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check("calib pulses", 24'(calibCnt), 24'h1);
    check("temp avg", 24'(temperatureAverages), 24'h10);
    check("press avg", 24'(pressureAverages), 24'h20);
    check("power", 24'(powerOn), 24'h0);
    check("three wire", 24'(spiThreeWire), 24'h0);
    check("event", 24'(thresholdEvent), 24'h0);
    @(posedge ref_clk);
    foreach (ra[i]) begin
      e = 8'h00;
      if (ra[i] == ADDR_IDENTITY) e = IDENTITY_VALUE;
      if (ra[i] == ADDR_AVG_CFG) e = {4'h0, AVG_CFG_RESET};
      rd(ra[i], e);
    end
    wr(ADDR_IDENTITY, ~IDENTITY_VALUE);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_IDENTITY, IDENTITY_VALUE);
    rd(ADDR_STATUS, 8'h00);
    v = 24'($urandom);
    wr(ADDR_REF_LOW, v[7:0]);
    wr(ADDR_REF_MID, v[15:8]);
    wr(ADDR_REF_HIGH, v[23:16]);
    rd3(ADDR_REF_LOW, v);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_AVG_CFG, 8'(c * 5));
      @(negedge ref_clk);
      check("temp avg", 24'(temperatureAverages), 24'(8 << c));
      check("press avg", 24'(pressureAverages), 24'(8 << (2 * c)));
      @(posedge ref_clk);
    end
    b = startCnt;
    wr(ADDR_MAIN_CTRL, 8'h81);
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    check("idle one-shot", 24'(startCnt - b), 24'h0);
    check("three wire", 24'(spiThreeWire), 24'h1);
    check("power", 24'(powerOn), 24'h1);
    @(posedge ref_clk);
    wr(ADDR_MAIN_CTRL, 8'h80);
    v = 24'($urandom);
    w = 24'($urandom);
    tIn <= w[15:0];
    oneShot(v, 8'h00);
    rd(ADDR_STATUS, 8'h03);
    rd(ADDR_SEC_CTRL, 8'h00);
    rd3(ADDR_POUT_LOW, v);
    rd(ADDR_TOUT_LOW, w[7:0]);
    rd(ADDR_TOUT_HIGH, w[15:8]);
    // slow replies would swallow ticks of the fastest code
    slow <= 1'b0;
    // faster codes must start more conversions in the same window
    for (int c = 1; c < 5; c++) begin
      wr(ADDR_MAIN_CTRL, 8'h80 | 8'(c << 4));
      b = startCnt;
      repeat (100) @(posedge ref_clk);
      n[c] = startCnt - b;
      check("rate starts", 24'(n[c] > n[c - 1]), 24'h1);
    end
    wr(ADDR_MAIN_CTRL, 8'h40);
    repeat (10) @(posedge ref_clk);
    b = startCnt;
    repeat (60) @(posedge ref_clk);
    check("starts when down", 24'(startCnt - b), 24'h0);
    wr(ADDR_MAIN_CTRL, 8'h84);
    rd(ADDR_POUT_LOW, v[7:0]);
    rd(ADDR_POUT_HIGH, v[23:16]);
    x = 24'($urandom);
    oneShot(x, 8'h00);
    oneShot(24'($urandom), 8'h00);
    rd3(ADDR_POUT_LOW, x);
    z = 24'($urandom);
    oneShot(z, 8'h00);
    rd3(ADDR_POUT_LOW, z);
    wr(ADDR_MAIN_CTRL, 8'h80);
    wr(ADDR_SEC_CTRL, 8'h02);
    rd3(ADDR_REF_LOW, z);
    x = 24'($urandom);
    oneShot(x, 8'h02);
    rd3(ADDR_POUT_LOW, x - z);
    wr(ADDR_AZP_LOW, 8'h5A);
    wr(ADDR_AZP_HIGH, 8'hA5);
    rd(ADDR_AZP_HIGH, 8'hA5);
    wr(ADDR_MAIN_CTRL, 8'h82);
    rd3(ADDR_REF_LOW, 24'h00_0000);
    rd(ADDR_AZP_LOW, 8'h00);
    rd(ADDR_AZP_HIGH, 8'h00);
    rd(ADDR_MAIN_CTRL, 8'h80);
    wr(ADDR_THS_LOW, 8'h10);
    wr(ADDR_THS_HIGH, 8'h00);
    wr(ADDR_EVT_CFG, 8'h01);
    oneShot(24'h00_0100, 8'h00);
    @(negedge ref_clk);
    check("event", 24'(thresholdEvent), 24'h0);
    @(posedge ref_clk);
    wr(ADDR_MAIN_CTRL, 8'h88);
    oneShot(24'h00_0100, 8'h00);
    @(negedge ref_clk);
    check("event", 24'(thresholdEvent), 24'h1);
    @(posedge ref_clk);
    rd(ADDR_EVT_SRC, 8'h05);
    print_verdict();
  end
endmodule
